// file: include/msfd_pkg.sv
// Purpose: Shared constants and frame layouts for the serial frame decoder.
// Assumes: 16-bit frames, MSB first; frame type in bit 0.
// Notes: Frame structs are declared MSB first so a received word casts straight in.
package msfd_pkg;

  localparam int FRAME_BITS = 16;
  localparam logic [0:0] FRAME_NORMAL = 1'h0;
  localparam logic [0:0] FRAME_CONFIG = 1'h1;

  // Sample-and-hold window, in serial clock periods
  localparam int SH_SCLK_PERIODS = 15;
  localparam logic [3:0] SH_LOAD = 4'(SH_SCLK_PERIODS - 1);

  // Single conversion pacing, in frames, sampling included
  localparam int PACE_SLOW_FRAMES = 4;
  localparam int PACE_FAST_FRAMES = 8;
  localparam logic [2:0] PACE_SLOW_LOAD = 3'(PACE_SLOW_FRAMES - 1);
  localparam logic [2:0] PACE_FAST_LOAD = 3'(PACE_FAST_FRAMES - 1);

  // Converter target channel codes (normal frame bits 4:2)
  localparam logic [2:0] TGT_AN0 = 3'h0;
  localparam logic [2:0] TGT_AN1 = 3'h1;
  localparam logic [2:0] TGT_ENC_AUTO = 3'h3;
  localparam logic [2:0] TGT_PAIR_A_B = 3'h4;
  localparam logic [2:0] TGT_PAIR_A_AN = 3'h5;
  localparam logic [2:0] TGT_PAIR_B_BN = 3'h6;
  localparam logic [2:0] TGT_PAIR_AN23 = 3'h7;

  // Source report codes (return word bits 6:4)
  localparam logic [2:0] REP_AN0 = 3'h0;
  localparam logic [2:0] REP_AN1 = 3'h1;
  localparam logic [2:0] REP_AN2 = 3'h2;
  localparam logic [2:0] REP_AN3 = 3'h3;
  localparam logic [2:0] REP_ENC_A = 3'h4;
  localparam logic [2:0] REP_ENC_B = 3'h5;
  localparam logic [2:0] REP_ENC_A_N = 3'h6;
  localparam logic [2:0] REP_ENC_B_N = 3'h7;

  // Information frame fixed fields
  localparam logic [5:0] INFO_RESERVED = 6'h18;
  localparam logic [0:0] INFO_MARK = 1'h1;

  localparam logic [15:0] NORM_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] TX_RESET = 16'h0000;

  typedef struct packed {
    logic aux_switch_two;
    logic aux_switch_one;
    logic phase_b_n;
    logic phase_b;
    logic [1:0] dir_c;
    logic [1:0] dir_a;
    logic [1:0] dir_b;
    logic gate_on;
    logic [2:0] conv_target_select;
    logic conv_start;
    logic frame_type;
  } msfd_norm_type;

  typedef struct packed {
    logic [1:0] test_bits;
    logic [4:0] cal_value;
    logic analog_test;
    logic [1:0] cal_addr;
    logic filter_sel;
    logic dc_or_step_select;
    logic conv_speed;
    logic sleep_req;
    logic info_frame_request;
    logic frame_type;
  } msfd_cfg_type;

endpackage

// file: rtl/msfd_frame_decoder.sv
// Purpose: Serial frame decoder: normal/config frames in, return word out, converter sequencing.
// Assumes: Host holds ce_n high at least 6 core_clk cycles between frames; sclk idles outside frames.
// Notes: Link shifting runs on sclk; decoding and converter pacing run on core_clk.
// How it works
// - Sample-and-hold output stays high fifteen serial clock periods per conversion.
// - First done flag for single or first-of-pair, second only for pair's second.
// - Done flag rising in a return word marks its data and source valid.
// - Each done flag is set in exactly one return word, or in none if an info word replaces that word.
// - Bits 6:4 report source: direct inputs, or encoder channel A/B with bit 6 set.
// - Frame with bit 0 clear is decoded as a normal control frame.
// - Start bit launches a conversion unless a conversion sequence is running and not ending in this frame.
// - Target channel comes from normal frame bits 4 to 2.
// - Normal frame bit 5 drives the gate output.
// - Bits 15 and 14 drive high-side or low-side switches per mode bit.
// - Bits 13 to 10 drive step phases; B phases unused in DC mode.
// - Driver C, A, B direction bits from bits 11:10, 9:8, 7:6.
// - Equal direction bits pass straight to driver A and B outputs, and to C in DC mode only, ignoring PWM.
// - All normal controls reset to zero; no conversion pending after reset.
// - Configuration frame fields decoded at their fixed bit positions.
// - Frame with bit 0 set latches configuration fields.
// - Return word carries the last eight-bit result in bits 15 to 8.
// - Info request makes the next return word an information frame.
// - Conversions paced at four frames, or eight with speed bit set.
`timescale 1ns/1ns
module msfd_frame_decoder (
  input wire logic core_clk, // System clock, 100 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic sclk, // Serial clock from host
  input wire logic ce_n, // Chip enable, active low
  input wire logic mosi, // Serial data in
  output logic miso, // Serial data out
  input wire logic encoder_digital_a, // Encoder digital A (pin)
  input wire logic encoder_digital_b, // Encoder digital B (pin)
  input wire logic [2:0] pwm_in, // PWM for drivers C, A, B (pin)
  input wire logic [7:0] conv_result_in, // Converter result from analog side (pin)
  output logic adc_sample, // Sample-and-hold window, sclk domain
  output logic [2:0] adc_mux_select, // Input now being converted, source code
  output logic conv_busy, // Conversion sequence in progress
  output logic gate_drive_output, // Gate output: 1 bias supply, 0 ground
  output logic [1:0] hs_switch_on, // High-side switches {two, one}
  output logic [1:0] ls_switch_on, // Low-side switches {two, one}
  output logic [3:0] step_phase_on, // Step phases {b_n, b, a_n, a}, on when 1
  output logic [1:0] drv_c_out, // Driver C outputs
  output logic [1:0] drv_a_out, // Driver A outputs
  output logic [1:0] drv_b_out, // Driver B outputs
  output msfd_pkg::msfd_cfg_type cfg_out, // Latched configuration fields
  output logic [3:0][4:0] cal_table // Calibration: A gain, A offset, B gain, B offset
);

  typedef enum logic [1:0] {MSFD_IDLE, MSFD_FIRST, MSFD_SECOND} msfd_conv_state_type;

  // Link domain
  logic rst_l1_reg;
  logic rst_l2_reg;
  logic [3:0] bit_cnt_reg;
  logic [15:0] rx_shift_reg;
  logic [15:0] tx_shift_reg;
  logic samp_l1_reg;
  logic samp_l2_reg;
  logic samp_ack_reg;
  logic [3:0] sh_cnt_reg;
  logic sample_reg;

  // Core domain
  logic ce_s1_reg;
  logic ce_s2_reg;
  logic ce_s3_reg;
  logic [12:0] pins_s1_reg;
  logic [12:0] pins_s2_reg;
  msfd_pkg::msfd_norm_type norm_reg;
  msfd_pkg::msfd_cfg_type cfg_reg;
  logic [3:0][4:0] cal_reg;
  logic [15:0] tx_word_reg;
  msfd_conv_state_type state_reg;
  logic [2:0] cnt_reg;
  logic [2:0] tgt_reg;
  logic [2:0] mux_sel_reg;
  logic [7:0] data_reg;
  logic [2:0] rep_reg;
  logic samp_tgl_reg;

  logic frame_end;
  logic is_normal;
  logic is_config;
  msfd_pkg::msfd_norm_type rx_norm;
  msfd_pkg::msfd_cfg_type rx_cfg;
  logic enc_a;
  logic enc_b;
  logic [2:0] pwm_s;
  logic [7:0] adc_s;
  logic finish;
  logic last_finish;
  logic launch;
  logic done_first;
  logic done_second;
  logic [7:0] data_now;
  logic [2:0] rep_now;
  logic [2:0] pace_load;
  logic dc_mode;

  // Source code of the input converted for a target, first or second of a pair
  function automatic logic [2:0] conv_src(input logic [2:0] tgt, input logic second,
                                          input logic ea, input logic eb);
    case (tgt)
      msfd_pkg::TGT_AN0: conv_src = msfd_pkg::REP_AN0;
      msfd_pkg::TGT_AN1: conv_src = msfd_pkg::REP_AN1;
      msfd_pkg::TGT_ENC_AUTO: conv_src = (ea ^ eb) ? msfd_pkg::REP_ENC_A : msfd_pkg::REP_ENC_B;
      msfd_pkg::TGT_PAIR_A_B: conv_src = second ? msfd_pkg::REP_ENC_B : msfd_pkg::REP_ENC_A;
      msfd_pkg::TGT_PAIR_A_AN: conv_src = second ? msfd_pkg::REP_ENC_A_N : msfd_pkg::REP_ENC_A;
      msfd_pkg::TGT_PAIR_B_BN: conv_src = second ? msfd_pkg::REP_ENC_B_N : msfd_pkg::REP_ENC_B;
      msfd_pkg::TGT_PAIR_AN23: conv_src = second ? msfd_pkg::REP_AN3 : msfd_pkg::REP_AN2;
      default: conv_src = msfd_pkg::REP_AN0;
    endcase
  endfunction

  // Equal bits force the outputs; otherwise the set bit is chopped by PWM
  function automatic logic [1:0] drive(input logic [1:0] dir, input logic pwm);
    drive = (dir[1] == dir[0]) ? dir : (dir & {2{pwm}});
  endfunction

  // sclk may stop at any time, so the link side takes reset through its own synchroniser
  always_ff @(posedge sclk) begin
    rst_l1_reg <= sys_rst;
    rst_l2_reg <= rst_l1_reg;
  end

  // frame bit counter
  // Cleared by the frame's own enable, since sclk does not run between frames
  always_ff @(posedge sclk or posedge ce_n) begin
    if (ce_n) begin
      bit_cnt_reg <= 4'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge sclk) begin
    if (rst_l2_reg) begin
      rx_shift_reg <= msfd_pkg::TX_RESET;
    end else begin
      rx_shift_reg <= {rx_shift_reg[14:0], mosi};
    end
  end

  // Return word is static while enable is low, so reading it here is safe
  always_ff @(posedge sclk) begin
    if (rst_l2_reg) begin
      tx_shift_reg <= msfd_pkg::TX_RESET;
    end else if (bit_cnt_reg == 4'h0) begin
      tx_shift_reg <= {tx_word_reg[14:0], 1'b0};
    end else begin
      tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
    end
  end

  assign miso = (bit_cnt_reg == 4'h0) ? tx_word_reg[15] : tx_shift_reg[15];

  // sample window of fifteen sclk periods
  always_ff @(posedge sclk) begin
    if (rst_l2_reg) begin
      samp_l1_reg <= 1'b0;
      samp_l2_reg <= 1'b0;
      samp_ack_reg <= 1'b0;
      sh_cnt_reg <= 4'h0;
      sample_reg <= 1'b0;
    end else begin
      samp_l1_reg <= samp_tgl_reg;
      samp_l2_reg <= samp_l1_reg;
      if (samp_l2_reg != samp_ack_reg) begin
        samp_ack_reg <= samp_l2_reg;
        sample_reg <= 1'b1;
        sh_cnt_reg <= msfd_pkg::SH_LOAD;
      end else if (sh_cnt_reg != 4'h0) begin
        sh_cnt_reg <= sh_cnt_reg - 4'h1;
      end else begin
        sample_reg <= 1'b0;
      end
    end
  end

  assign adc_sample = sample_reg;

  // window length count
  // Counted in helper logic, since a fifteen-deep repetition would be unrolled
  logic [4:0] sh_len_reg;
  always_ff @(posedge sclk) begin
    if (rst_l2_reg || !sample_reg) begin
      sh_len_reg <= 5'h00;
    end else begin
      sh_len_reg <= sh_len_reg + 5'h01;
    end
  end

  AST_SH_WINDOW: assert property (@(posedge sclk) disable iff (rst_l2_reg)
    $fell(sample_reg) |-> (sh_len_reg == 5'(msfd_pkg::SH_SCLK_PERIODS)))
    else $error("sample window is not fifteen sclk periods");

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ce_s1_reg <= 1'b1;
      ce_s2_reg <= 1'b1;
      ce_s3_reg <= 1'b1;
      pins_s1_reg <= 13'h0000;
      pins_s2_reg <= 13'h0000;
    end else begin
      ce_s1_reg <= ce_n;
      ce_s2_reg <= ce_s1_reg;
      ce_s3_reg <= ce_s2_reg;
      pins_s1_reg <= {conv_result_in, pwm_in, encoder_digital_b, encoder_digital_a};
      pins_s2_reg <= pins_s1_reg;
    end
  end

  assign frame_end = ce_s2_reg & ~ce_s3_reg;
  assign rx_norm = msfd_pkg::msfd_norm_type'(rx_shift_reg);
  assign rx_cfg = msfd_pkg::msfd_cfg_type'(rx_shift_reg);
  // bit 0 clear means normal frame
  assign is_normal = frame_end && (rx_shift_reg[0] == msfd_pkg::FRAME_NORMAL);
  // bit 0 set means configuration frame
  assign is_config = frame_end && (rx_shift_reg[0] == msfd_pkg::FRAME_CONFIG);
  assign enc_a = pins_s2_reg[0];
  assign enc_b = pins_s2_reg[1];
  assign pwm_s = pins_s2_reg[4:2];
  assign adc_s = pins_s2_reg[12:5];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      norm_reg <= msfd_pkg::msfd_norm_type'(msfd_pkg::NORM_RESET);
    end else if (is_normal) begin
      norm_reg <= rx_norm;
    end
  end

  AST_CFG_KEEPS_NORMAL: assert property (@(posedge core_clk) disable iff (sys_rst)
    is_config |=> $stable(norm_reg))
    else $error("configuration frame changed normal controls");

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_reg <= msfd_pkg::msfd_cfg_type'(msfd_pkg::CFG_RESET);
      cal_reg <= '0;
    end else if (is_config) begin
      cfg_reg <= rx_cfg;
      cal_reg[rx_cfg.cal_addr] <= rx_cfg.cal_value;
    end
  end

  assign cfg_out = cfg_reg;
  assign cal_table = cal_reg;

  AST_CFG_LATCH: assert property (@(posedge core_clk) disable iff (sys_rst)
    is_config |=> (cfg_reg == $past(rx_cfg)) && (cal_reg[$past(rx_cfg.cal_addr)] == $past(rx_cfg.cal_value)))
    else $error("configuration frame not latched");

  assign pace_load = cfg_reg.conv_speed ? msfd_pkg::PACE_FAST_LOAD : msfd_pkg::PACE_SLOW_LOAD;
  assign finish = frame_end && (state_reg != MSFD_IDLE) && (cnt_reg == 3'h1);
  assign last_finish = finish && ((state_reg == MSFD_SECOND) || !tgt_reg[2]);
  assign launch = is_normal && rx_norm.conv_start && ((state_reg == MSFD_IDLE) || last_finish);
  // flag selection by position in pair
  assign done_first = finish && (state_reg == MSFD_FIRST);
  assign done_second = finish && (state_reg == MSFD_SECOND);
  assign data_now = finish ? adc_s : data_reg;
  assign rep_now = finish ? mux_sel_reg : rep_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= MSFD_IDLE;
      cnt_reg <= 3'h0;
      tgt_reg <= 3'h0;
      mux_sel_reg <= 3'h0;
      samp_tgl_reg <= 1'b0;
    end else if (launch) begin
      state_reg <= MSFD_FIRST;
      cnt_reg <= pace_load;
      tgt_reg <= rx_norm.conv_target_select;
      mux_sel_reg <= conv_src(rx_norm.conv_target_select, 1'b0, enc_a, enc_b);
      samp_tgl_reg <= ~samp_tgl_reg;
    end else if (frame_end) begin
      case (state_reg)
        MSFD_IDLE: begin
          state_reg <= MSFD_IDLE;
        end
        MSFD_FIRST: begin
          if (cnt_reg != 3'h1) begin
            cnt_reg <= cnt_reg - 3'h1;
          end else if (tgt_reg[2]) begin
            state_reg <= MSFD_SECOND;
            cnt_reg <= pace_load;
            mux_sel_reg <= conv_src(tgt_reg, 1'b1, enc_a, enc_b);
            samp_tgl_reg <= ~samp_tgl_reg;
          end else begin
            state_reg <= MSFD_IDLE;
          end
        end
        MSFD_SECOND: begin
          if (cnt_reg != 3'h1) begin
            cnt_reg <= cnt_reg - 3'h1;
          end else begin
            state_reg <= MSFD_IDLE;
          end
        end
        default: begin
          state_reg <= MSFD_IDLE;
        end
      endcase
    end
  end

  assign conv_busy = (state_reg != MSFD_IDLE);
  assign adc_mux_select = mux_sel_reg;

  AST_START_IGNORED: assert property (@(posedge core_clk) disable iff (sys_rst)
    (is_normal && rx_norm.conv_start && conv_busy && !last_finish) |=>
      $stable(tgt_reg) && ($past(finish) || $stable(samp_tgl_reg)))
    else $error("start accepted while converting");

  AST_PACE_SLOW: assert property (@(posedge core_clk) disable iff (sys_rst)
    (launch && !cfg_reg.conv_speed) |=> (cnt_reg == 3'h3) && (state_reg == MSFD_FIRST))
    else $error("slow pacing not four frames");

  // last result held for the return word
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      data_reg <= 8'h00;
      rep_reg <= 3'h0;
    end else if (finish) begin
      data_reg <= adc_s;
      rep_reg <= mux_sel_reg;
    end
  end

  // done, data and source set together
  // flags rebuilt every frame, so each stands one frame
  // info word replaces the normal word once
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_word_reg <= msfd_pkg::TX_RESET;
    end else if (frame_end) begin
      if (is_config && rx_cfg.info_frame_request) begin
        tx_word_reg <= {msfd_pkg::INFO_RESERVED, 2'b00, msfd_pkg::INFO_MARK, 3'b000, enc_b, enc_a, 2'b00};
      end else begin
        tx_word_reg <= {data_now, 1'b0, rep_now, enc_b, enc_a, done_second, done_first};
      end
    end
  end

  AST_DONE_ONE_FRAME: assert property (@(posedge core_clk) disable iff (sys_rst)
    (frame_end && (tx_word_reg[1:0] != 2'b00)) |=> (tx_word_reg[1:0] == 2'b00))
    else $error("done flag held past one frame");

  AST_DONE_PAIRING: assert property (@(posedge core_clk) disable iff (sys_rst)
    done_second |-> (tgt_reg[2] && !done_first) ##1 ((tx_word_reg[1:0] == 2'b10) && !tx_word_reg[7]))
    else $error("second done flag outside a pair");

  AST_DONE_DATA: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(tx_word_reg[0]) |-> (tx_word_reg[15:8] == $past(adc_s)) && (tx_word_reg[6:4] == $past(mux_sel_reg)))
    else $error("done word does not carry the finished result");

  // switch bank chosen by mode bit
  // B phases dropped in DC mode
  assign dc_mode = !cfg_reg.dc_or_step_select;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gate_drive_output <= 1'b0;
      hs_switch_on <= 2'b00;
      ls_switch_on <= 2'b00;
      step_phase_on <= 4'h0;
      drv_c_out <= 2'b00;
      drv_a_out <= 2'b00;
      drv_b_out <= 2'b00;
    end else begin
      gate_drive_output <= norm_reg.gate_on;
      hs_switch_on <= dc_mode ? 2'b00 : {norm_reg.aux_switch_two, norm_reg.aux_switch_one};
      ls_switch_on <= dc_mode ? {norm_reg.aux_switch_two, norm_reg.aux_switch_one} : 2'b00;
      step_phase_on <= {dc_mode ? 2'b00 : {norm_reg.phase_b_n, norm_reg.phase_b}, norm_reg.dir_c};
      drv_c_out <= dc_mode ? drive(norm_reg.dir_c, pwm_s[0]) : 2'b00;
      drv_a_out <= drive(norm_reg.dir_a, pwm_s[1]);
      drv_b_out <= drive(norm_reg.dir_b, pwm_s[2]);
    end
  end

  AST_GATE_FOLLOWS: assert property (@(posedge core_clk) disable iff (sys_rst)
    is_normal |-> ##2 (gate_drive_output == $past(rx_shift_reg[5], 2)))
    else $error("gate output does not follow frame bit 5");

  AST_DIR_EQUAL: assert property (@(posedge core_clk) disable iff (sys_rst)
    (norm_reg.dir_a[1] == norm_reg.dir_a[0]) |=> (drv_a_out == $past(norm_reg.dir_a)))
    else $error("equal direction bits not passed through");

  AST_SWITCH_BANK: assert property (@(posedge core_clk) disable iff (sys_rst)
    dc_mode |=> (hs_switch_on == 2'b00) && (ls_switch_on == $past({norm_reg.aux_switch_two, norm_reg.aux_switch_one})))
    else $error("switch bank wrong for mode");

  AST_RESET_CLEAR: assert property (@(posedge core_clk)
    sys_rst |=> (norm_reg == msfd_pkg::msfd_norm_type'(msfd_pkg::NORM_RESET)) && !conv_busy)
    else $error("controls not cleared by reset");

endmodule // msfd_frame_decoder

// file: verif/msfd_host_model.sv
// Purpose: Host side of the four-wire frame link, driving sclk, ce_n and mosi.
// Assumes: sclk period 80 ns within frames (20 ns in the reset flush), idle low outside frames after the flush.
// Notes: mosi is inverted after each frame so a stale bit never looks valid.
`timescale 1ns/1ns
module msfd_host_model (
  output logic sclk, // Serial clock, runs within frames and in the reset flush
  output logic ce_n, // Chip enable, active low
  output logic mosi, // Data to the device
  input wire logic miso // Data from the device
);
  initial begin
    sclk = 1'b0;
    ce_n = 1'b1;
    mosi = 1'b0;
  end

  // Link registers clear only while sclk runs during reset, so pulse it briefly
  task automatic flush_link();
    repeat (4) begin
      #10 sclk = 1'b1;
      #10 sclk = 1'b0;
    end
  endtask

  task automatic xfer(input logic [15:0] word, output logic [15:0] rx);
    ce_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = word[i];
      #40 rx[i] = miso;
      sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #40 ce_n = 1'b1;
    mosi = ~mosi;
    // Gap well above six core cycles lets the decode and outputs settle
    #100;
  endtask
endmodule // msfd_host_model

// file: verif/msfd_frame_decoder_bench.sv
// Purpose: Self-checking bench for the serial frame decoder.
// Assumes: Host model owns the link pins; core inputs change on core_clk.
// Notes: Return words are judged field by field since encoder bits change.
`timescale 1ns/1ns
module msfd_frame_decoder_bench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sclk;
  logic ce_n;
  logic mosi;
  logic miso;
  logic encoder_digital_a = 1'b0;
  logic encoder_digital_b = 1'b0;
  logic [2:0] pwm_in = 3'h0;
  logic [7:0] conv_result_in = 8'h00;
  logic adc_sample;
  logic [2:0] adc_mux_select;
  logic conv_busy;
  logic gate_drive_output;
  logic [1:0] hs_switch_on;
  logic [1:0] ls_switch_on;
  logic [3:0] step_phase_on;
  logic [1:0] drv_c_out;
  logic [1:0] drv_a_out;
  logic [1:0] drv_b_out;
  msfd_pkg::msfd_cfg_type cfg_out;
  logic [3:0][4:0] cal_table;
  logic [15:0] outs;
  logic [15:0] rx;
  int failures = 0;
  int check_count = 0;
  int sh_count = 0;

  assign outs = {gate_drive_output, hs_switch_on, ls_switch_on, step_phase_on, drv_c_out, drv_a_out, drv_b_out,
                 conv_busy};

  always #5 core_clk = ~core_clk;

  always @(posedge sclk) begin
    if (adc_sample === 1'b1) begin
      sh_count++;
    end
  end

  msfd_frame_decoder msfd_frame_decoder_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk), .ce_n(ce_n), .mosi(mosi), .miso(miso),
    .encoder_digital_a(encoder_digital_a), .encoder_digital_b(encoder_digital_b), .pwm_in(pwm_in),
    .conv_result_in(conv_result_in), .adc_sample(adc_sample), .adc_mux_select(adc_mux_select),
    .conv_busy(conv_busy), .gate_drive_output(gate_drive_output), .hs_switch_on(hs_switch_on),
    .ls_switch_on(ls_switch_on), .step_phase_on(step_phase_on), .drv_c_out(drv_c_out),
    .drv_a_out(drv_a_out), .drv_b_out(drv_b_out), .cfg_out(cfg_out), .cal_table(cal_table)
  );

  msfd_host_model msfd_host_model_inst (.sclk(sclk), .ce_n(ce_n), .mosi(mosi), .miso(miso));

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic frame(input logic [15:0] w);
    msfd_host_model_inst.xfer(w, rx);
  endtask

  task automatic test_reset();
    check("outputs", 16'h0000, outs);
    check("cfg", 16'h0000, cfg_out);
    frame(16'h0000);
    check("return", 16'h0000, rx);
  endtask

  task automatic test_config();
    frame(16'haca1);
    check("cfg", 16'haca1, cfg_out);
    check("cal", 16'h0016, cal_table[2]);
  endtask

  task automatic test_outputs();
    @(posedge core_clk);
    pwm_in <= 3'h1;
    frame(16'hb720);
    check("dc_outs", 16'h90b8, outs);
    frame(16'h0011);
    check("step_outs", 16'hc698, outs);
    frame(16'h0001);
  endtask

  task automatic test_info();
    @(posedge core_clk);
    encoder_digital_a <= 1'b1;
    frame(16'h0003);
    frame(16'h0000);
    check("info", 16'h6084, rx);
    frame(16'h0001);
  endtask

  // Start, refused restart, then watch done flags, data and source per frame
  task automatic do_conv(input logic [2:0] tgt, input int pace, input logic pair, input logic [2:0] rep1,
                         input logic [2:0] rep2);
    int last;
    int sh_start;
    last = pair ? 2 * pace : pace + 1;
    @(posedge core_clk);
    conv_result_in <= 8'h5a;
    sh_start = sh_count;
    frame({11'h000, tgt, 2'b10});
    check("busy", 16'h0001, conv_busy);
    check("mux1", rep1, adc_mux_select);
    for (int f = 1; f <= last; f++) begin
      frame(f == 1 ? {11'h000, ~tgt, 2'b10} : 16'h0000);
      check("done", {pair && f == 2 * pace - 1, f == pace}, rx[1:0]);
      if (f == pace) begin
        check("data1", 16'h005a, rx[15:8]);
        check("src1", rep1, rx[6:4]);
        check("mux2", pair ? rep2 : rep1, adc_mux_select);
        @(posedge core_clk);
        conv_result_in <= 8'ha5;
      end
      if (f == pace + 1) begin
        check("held", 16'h005a, rx[15:8]);
      end
      if (pair && f == 2 * pace - 1) begin
        check("data2", 16'h00a5, rx[15:8]);
        check("src2", rep2, rx[6:4]);
      end
    end
    check("sample", pair ? 16'd30 : 16'd15, 16'(sh_count - sh_start));
    check("idle", 16'h0000, conv_busy);
  endtask

  initial begin
    #300000;
    failures++;
    stop_test();
  end

  initial begin
    fork
      msfd_host_model_inst.flush_link();
    join_none
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    test_reset();
    test_config();
    test_outputs();
    test_info();
    do_conv(msfd_pkg::TGT_AN1, 4, 1'b0, msfd_pkg::REP_AN1, msfd_pkg::REP_AN1);
    do_conv(msfd_pkg::TGT_PAIR_AN23, 4, 1'b1, msfd_pkg::REP_AN2, msfd_pkg::REP_AN3);
    do_conv(msfd_pkg::TGT_PAIR_A_B, 4, 1'b1, msfd_pkg::REP_ENC_A, msfd_pkg::REP_ENC_B);
    do_conv(msfd_pkg::TGT_ENC_AUTO, 4, 1'b0, msfd_pkg::REP_ENC_A, msfd_pkg::REP_ENC_A);
    frame(16'h0009);
    do_conv(msfd_pkg::TGT_AN0, 8, 1'b0, msfd_pkg::REP_AN0, msfd_pkg::REP_AN0);
    stop_test();
  end
endmodule // msfd_frame_decoder_bench
